// ---- adv_pkg.sv ----
// Constants and types for the auto-negotiation advertisement register
`default_nettype none

package adv_pkg;

    // ==========================================================
    // Register addressing
    localparam logic [4:0]  ADV_REG_IDX     = 5'h04;

    // ==========================================================
    // Field positions
    localparam int          NEXT_PAGE_BIT   = 15;
    localparam int          RSVD_BIT        = 14;
    localparam int          REMOTE_FAULT_BIT = 13;
    localparam int          EXT_NP_BIT      = 12;
    localparam int          ASYM_PAUSE_BIT  = 11;
    localparam int          PAUSE_BIT       = 10;
    localparam int          FOUR_PAIR_BIT   = 9;
    localparam int          FAST_FULL_BIT   = 8;
    localparam int          FAST_HALF_BIT   = 7;
    localparam int          SLOW_FULL_BIT   = 6;
    localparam int          SLOW_HALF_BIT   = 5;
    localparam int          SEL_MSB         = 4;
    localparam int          SEL_LSB         = 0;

    // ==========================================================
    // Reset value and writable mask
    localparam logic [15:0] ADV_RESET_VAL   = 16'h1DE1;
    localparam logic [15:0] ADV_WR_MASK     = 16'hBDFF;
    localparam logic [4:0]  SEL_IEEE_8023   = 5'h01;
    localparam logic [15:0] ZERO_WORD       = 16'h0000;

    // ==========================================================
    // Why the advertisement was last applied
    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_SOFT_RESET,
        CAUSE_RESTART,
        CAUSE_PD_EXIT,
        CAUSE_LINK_LOSS
    } apply_cause_t;

endpackage

`default_nettype wire

// ---- adv_stage_if.sv ----
// Carrier between the register front end and the staged store
`timescale 1ns/1ps
`default_nettype none

interface adv_stage_if;
    logic        wr_en;
    logic [15:0] wr_data;
    logic        apply;
    logic [15:0] pending;
    logic [15:0] active;

    modport ctrl  (output wr_en, output wr_data, output apply, input pending, input active);
    modport store (input wr_en, input wr_data, input apply, output pending, output active);
endinterface

`default_nettype wire

// ---- staged_word.sv ----
// Two-stage word store: pending copy written at once, active copy on apply
`timescale 1ns/1ps
`default_nettype none

module staged_word #(
    parameter logic [15:0] RESET_VAL = 16'h0000,
    parameter logic [15:0] WR_MASK   = 16'hFFFF
) (
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    adv_stage_if.store  st
);

    logic [15:0] pending_r;
    logic [15:0] active_r;
    logic [15:0] wr_masked;

    // ==========================================================
    // Read-only positions never store a one
    assign wr_masked  = st.wr_data & WR_MASK;
    assign st.pending = pending_r;
    assign st.active  = active_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_r <= RESET_VAL;
        end else if (st.wr_en) begin
            pending_r <= wr_masked;
        end
    end

    // Write in the apply cycle goes straight through, nothing is lost
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_r <= RESET_VAL;
        end else if (st.apply) begin
            active_r <= st.wr_en ? wr_masked : pending_r;
        end
    end

endmodule

`default_nettype wire

// ---- autoneg_advert_register.sv ----
// Auto-negotiation advertisement register with deferred take-effect
// ==========================================================
// How it works
// - Writes store at once; negotiation sees them only after an apply event
// - Soft reset request from the control register applies pending contents
// - Negotiation restart applies pending contents before the new negotiation
// - Leaving power-down applies pending contents
// - Next page set with gigabit advertised sends mandatory pages automatically
// - Bit 13 remote fault, writable, resets to zero
// - Bit 12 extended next page enable, writable, resets to one
// - Bit 11 asymmetric pause ability, writable, resets to one
// - Bit 10 pause ability, writable, resets to one
// - Bit 9 four-pair ability is read-only zero
// - Bits 8 to 5 speed and duplex abilities, writable, reset to one
// - Bits 4 to 0 selector, writable, resets to 00001
// - Bit 14 reserved, read-only zero
`timescale 1ns/1ps
`default_nettype none

module autoneg_advert_register (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic [4:0]        mgmt_reg_addr,
    input  wire logic              mgmt_wr_en,
    input  wire logic [15:0]       mgmt_wr_data,
    input  wire logic              mgmt_rd_en,
    output logic [15:0]            mgmt_rd_data,
    output logic                   mgmt_rd_valid,
    input  wire logic              ctrl_soft_reset,
    input  wire logic              ctrl_an_restart,
    input  wire logic              ctrl_power_down,
    input  wire logic              link_up,
    input  wire logic              gig_advertised,
    output logic [15:0]            adv_active,
    output logic                   adv_apply,
    output adv_pkg::apply_cause_t  apply_cause,
    output logic                   auto_next_page_en
);
    import adv_pkg::*;

    adv_stage_if st ();

    logic         wr_hit;
    logic         rd_hit;
    logic         pd_prev_r;
    logic         link_prev_r;
    logic         pd_exit;
    logic         link_loss;
    logic         apply_now;
    logic         adv_apply_r;
    logic [15:0]  rd_data_r;
    logic         rd_valid_r;
    logic         np_auto_r;
    logic         seen_r;
    apply_cause_t cause_r;
    apply_cause_t cause_nxt;

    // ==========================================================
    // Address decode
    always_comb begin
        if (mgmt_reg_addr == ADV_REG_IDX) begin
            wr_hit = mgmt_wr_en;
            rd_hit = mgmt_rd_en;
        end else begin
            wr_hit = 1'b0;
            rd_hit = 1'b0;
        end
    end

    // ==========================================================
    // Apply events
    // Edge memories reset low so no false exit is seen after reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_prev_r <= 1'b0;
        end else begin
            pd_prev_r <= ctrl_power_down;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_prev_r <= 1'b0;
        end else begin
            link_prev_r <= link_up;
        end
    end

    assign pd_exit   = pd_prev_r & ~ctrl_power_down;
    assign link_loss = link_prev_r & ~link_up;
    assign apply_now = ctrl_soft_reset | ctrl_an_restart | pd_exit | link_loss;

    // Soft reset reported first when several coincide
    always_comb begin
        if (ctrl_soft_reset) begin
            cause_nxt = CAUSE_SOFT_RESET;
        end else if (ctrl_an_restart) begin
            cause_nxt = CAUSE_RESTART;
        end else if (pd_exit) begin
            cause_nxt = CAUSE_PD_EXIT;
        end else if (link_loss) begin
            cause_nxt = CAUSE_LINK_LOSS;
        end else begin
            cause_nxt = cause_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cause_r <= CAUSE_NONE;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // ==========================================================
    // Staged store
    // pending written now, active on apply
    assign st.wr_en   = wr_hit;
    assign st.wr_data = mgmt_wr_data;
    assign st.apply   = apply_now;

    // mask drops bits 14 and 9
    staged_word #(
        .RESET_VAL (ADV_RESET_VAL),
        .WR_MASK   (ADV_WR_MASK)
    ) u_store (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .st       (st.store)
    );

    // Pulse marks the cycle the new word is visible
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            adv_apply_r <= 1'b0;
        end else begin
            adv_apply_r <= apply_now;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            np_auto_r <= 1'b0;
        end else begin
            np_auto_r <= st.active[NEXT_PAGE_BIT] & gig_advertised;
        end
    end

    // ==========================================================
    // Register read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= ZERO_WORD;
        end else if (rd_hit) begin
            rd_data_r <= st.pending;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_hit;
        end
    end

    assign mgmt_rd_data      = rd_data_r;
    assign mgmt_rd_valid     = rd_valid_r;
    assign adv_active        = st.active;
    assign adv_apply         = adv_apply_r;
    assign apply_cause       = cause_r;
    assign auto_next_page_en = np_auto_r;

    // ==========================================================
    // Checks
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_r <= 1'b0;
        end else begin
            seen_r <= 1'b1;
        end
    end

    chk_ro_bits_zero: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        st.pending[RSVD_BIT] == 1'b0 && st.pending[FOUR_PAIR_BIT] == 1'b0
        && adv_active[RSVD_BIT] == 1'b0 && adv_active[FOUR_PAIR_BIT] == 1'b0)
        else $error("read-only advertisement bit is set");

    chk_write_masked: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_hit |=> st.pending == ($past(mgmt_wr_data) & ADV_WR_MASK))
        else $error("written advertisement not stored masked");

    // active word holds without an event
    chk_active_holds: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !apply_now |=> $stable(adv_active))
        else $error("active advertisement changed with no apply event");

    chk_soft_reset_apply: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ctrl_soft_reset && !wr_hit |=> adv_active == $past(st.pending) && adv_apply)
        else $error("soft reset did not apply pending advertisement");

    chk_restart_apply: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ctrl_an_restart && !wr_hit |=> adv_active == $past(st.pending) && adv_apply)
        else $error("restart did not apply pending advertisement");

    chk_pd_exit_apply: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $fell(ctrl_power_down) && !wr_hit |=> adv_active == $past(st.pending))
        else $error("power-down exit did not apply pending advertisement");

    // automatic next pages follow active word
    chk_auto_next_page: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ##1 auto_next_page_en == ($past(adv_active[NEXT_PAGE_BIT]) && $past(gig_advertised)))
        else $error("automatic next page enable wrong");

    chk_reset_defaults: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !seen_r |-> st.pending == ADV_RESET_VAL && adv_active == ADV_RESET_VAL
        && adv_active[SEL_MSB:SEL_LSB] == SEL_IEEE_8023)
        else $error("advertisement reset value wrong");

    chk_read_pending: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rd_hit |=> mgmt_rd_valid && mgmt_rd_data == $past(st.pending))
        else $error("read data differs from stored advertisement");

    chk_link_loss_apply: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $fell(link_up) |=> adv_apply ##1 !adv_apply || $past(apply_now))
        else $error("link loss did not pulse apply");

    chk_apply_pulse: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> adv_apply == $past(apply_now))
        else $error("apply pulse does not follow trigger");

    // write in trigger cycle goes through
    chk_write_through: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_hit && apply_now |=> adv_active == ($past(mgmt_wr_data) & ADV_WR_MASK))
        else $error("write in apply cycle not taken into active word");

    chk_soft_reset_cause: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ctrl_soft_reset |=> apply_cause == CAUSE_SOFT_RESET)
        else $error("soft reset not reported as apply cause");

    chk_restart_cause: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ctrl_an_restart && !ctrl_soft_reset |=> apply_cause == CAUSE_RESTART)
        else $error("restart not reported as apply cause");

    chk_unmapped_quiet: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !rd_hit |=> !mgmt_rd_valid)
        else $error("read valid without a read of this register");

    cov_soft_and_restart: cover property (
        @(posedge core_clk) disable iff (!rst_n)
        ctrl_soft_reset && ctrl_an_restart);

    cov_write_then_restart: cover property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_hit ##[1:8] ctrl_an_restart);

    cov_pd_exit: cover property (
        @(posedge core_clk) disable iff (!rst_n)
        pd_exit ##1 adv_apply);

    cov_auto_np: cover property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(auto_next_page_en));

    cov_write_in_apply: cover property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_hit && apply_now);

endmodule

`default_nettype wire

// ---- adv_host_model.sv ----
// Management host model driving the advertisement register and control triggers
`timescale 1ns/1ps
`default_nettype none

module adv_host_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] mgmt_rd_data,
    input  wire logic        mgmt_rd_valid,
    output logic [4:0]       mgmt_reg_addr,
    output logic             mgmt_wr_en,
    output logic [15:0]      mgmt_wr_data,
    output logic             mgmt_rd_en,
    output logic             ctrl_soft_reset,
    output logic             ctrl_an_restart,
    output logic             ctrl_power_down,
    output logic             link_up,
    output logic             gig_advertised
);
    // ==========================================================
    // Idle levels; link starts up so release gives no loss event
    initial begin
        mgmt_reg_addr   = 5'h00;
        mgmt_wr_en      = 1'b0;
        mgmt_wr_data    = 16'h0000;
        mgmt_rd_en      = 1'b0;
        ctrl_soft_reset = 1'b0;
        ctrl_an_restart = 1'b0;
        ctrl_power_down = 1'b0;
        link_up         = 1'b1;
        gig_advertised  = 1'b0;
    end

    // ==========================================================
    // Register access, one-cycle strobes
    // callers set next page both with and without gigabit advertised
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        mgmt_reg_addr <= a;
        mgmt_wr_data  <= d;
        mgmt_wr_en    <= 1'b1;
        @(posedge core_clk);
        mgmt_wr_en    <= 1'b0;
    endtask

    // Answer is registered on the taking edge and read just after it
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
        @(posedge core_clk);
        mgmt_reg_addr <= a;
        mgmt_rd_en    <= 1'b1;
        @(posedge core_clk);
        mgmt_rd_en    <= 1'b0;
        #1;
        d = mgmt_rd_data;
        v = mgmt_rd_valid;
    endtask

    // Write and both control pulses on one edge
    task automatic wr_trig(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        mgmt_reg_addr   <= a;
        mgmt_wr_data    <= d;
        mgmt_wr_en      <= 1'b1;
        ctrl_soft_reset <= 1'b1;
        ctrl_an_restart <= 1'b1;
        @(posedge core_clk);
        mgmt_wr_en      <= 1'b0;
        ctrl_soft_reset <= 1'b0;
        ctrl_an_restart <= 1'b0;
        #1;
    endtask

    task automatic set_gig(input logic g);
        @(posedge core_clk);
        gig_advertised <= g;
    endtask

    // ==========================================================
    // Apply triggers: 0 soft reset, 1 restart, 2 power-down exit, 3 link loss
    // Returns just after the edge that takes the trigger
    task automatic trig(input int k);
        if (k == 2) begin
            @(posedge core_clk);
            ctrl_power_down <= 1'b1;
            @(posedge core_clk);
        end
        @(posedge core_clk);
        case (k)
            0: ctrl_soft_reset <= 1'b1;
            1: ctrl_an_restart <= 1'b1;
            2: ctrl_power_down <= 1'b0;
            default: link_up <= 1'b0;
        endcase
        @(posedge core_clk);
        ctrl_soft_reset <= 1'b0;
        ctrl_an_restart <= 1'b0;
        link_up         <= 1'b1;
        #1;
    endtask
endmodule

`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the advertisement register
`timescale 1ns/1ps
`default_nettype none

module tb;
    import adv_pkg::*;

    logic                 core_clk;
    logic                 rst_n;
    logic [4:0]           mgmt_reg_addr;
    logic                 mgmt_wr_en;
    logic [15:0]          mgmt_wr_data;
    logic                 mgmt_rd_en;
    logic [15:0]          mgmt_rd_data;
    logic                 mgmt_rd_valid;
    logic                 ctrl_soft_reset;
    logic                 ctrl_an_restart;
    logic                 ctrl_power_down;
    logic                 link_up;
    logic                 gig_advertised;
    logic [15:0]          adv_active;
    logic                 adv_apply;
    apply_cause_t         apply_cause;
    logic                 auto_next_page_en;
    logic [15:0]          act_exp;
    int                   n_fail;
    int                   n_compared;
    int                   cyc;

    autoneg_advert_register dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .mgmt_reg_addr(mgmt_reg_addr),
        .mgmt_wr_en(mgmt_wr_en), .mgmt_wr_data(mgmt_wr_data), .mgmt_rd_en(mgmt_rd_en),
        .mgmt_rd_data(mgmt_rd_data), .mgmt_rd_valid(mgmt_rd_valid),
        .ctrl_soft_reset(ctrl_soft_reset), .ctrl_an_restart(ctrl_an_restart),
        .ctrl_power_down(ctrl_power_down), .link_up(link_up),
        .gig_advertised(gig_advertised), .adv_active(adv_active), .adv_apply(adv_apply),
        .apply_cause(apply_cause), .auto_next_page_en(auto_next_page_en)
    );

    adv_host_model host_u (
        .core_clk(core_clk), .mgmt_rd_data(mgmt_rd_data), .mgmt_rd_valid(mgmt_rd_valid),
        .mgmt_reg_addr(mgmt_reg_addr), .mgmt_wr_en(mgmt_wr_en),
        .mgmt_wr_data(mgmt_wr_data), .mgmt_rd_en(mgmt_rd_en),
        .ctrl_soft_reset(ctrl_soft_reset), .ctrl_an_restart(ctrl_an_restart),
        .ctrl_power_down(ctrl_power_down), .link_up(link_up),
        .gig_advertised(gig_advertised)
    );

    // ==========================================================
    // Clock, reset, hang guard sized well above the sequence length
    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    initial begin
        cyc = 0;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end

    // ==========================================================
    // Compare and report
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic s_reset();
        logic [15:0] d;
        logic        v;
        check("active_at_reset", adv_active, ADV_RESET_VAL);
        check("cause_at_reset", {13'h0000, apply_cause}, ZERO_WORD);
        host_u.rd(ADV_REG_IDX, d, v);
        check("rd_valid", {15'h0000, v}, 16'h0001);
        check("reset_word", d, 16'h1DE1);
    endtask

    // Read-only bits drop writes; other address neither answers nor stores
    task automatic s_write(input logic [4:0] a, input logic [15:0] w, input logic [15:0] e);
        logic [15:0] d;
        logic        v;
        host_u.wr(a, w);
        host_u.rd(ADV_REG_IDX, d, v);
        check("stored_word", d, e);
        check("active_held", adv_active, ADV_RESET_VAL);
        host_u.rd(5'h05, d, v);
        check("unmapped_valid", {15'h0000, v}, 16'h0000);
        check("unmapped_data", d, e);
    endtask

    task automatic s_apply(input int k, input logic [15:0] w);
        logic [15:0] exp_c;
        exp_c = (k == 0) ? 16'h0001 : (k == 1) ? 16'h0002 : (k == 2) ? 16'h0003 : 16'h0004;
        host_u.wr(ADV_REG_IDX, w);
        check("active_before", adv_active, act_exp);
        host_u.trig(k);
        act_exp = w & ADV_WR_MASK;
        check("active_after", adv_active, act_exp);
        check("apply_pulse", {15'h0000, adv_apply}, 16'h0001);
        check("apply_cause", {13'h0000, apply_cause}, exp_c);
        @(posedge core_clk);
        #1;
        check("apply_end", {15'h0000, adv_apply}, 16'h0000);
    endtask

    // Automatic pages only with next page set and gigabit advertised
    task automatic s_next_page(input logic g, input logic [15:0] w, input logic e);
        host_u.set_gig(g);
        s_apply(1, w);
        check("auto_np", {15'h0000, auto_next_page_en}, {15'h0000, e});
    endtask

    // Write meeting soft reset and restart: data goes through, soft reset named
    task automatic s_write_apply(input logic [15:0] w);
        logic [15:0] d;
        logic        v;
        check("active_before", adv_active, act_exp);
        host_u.wr_trig(ADV_REG_IDX, w);
        act_exp = w & ADV_WR_MASK;
        check("active_through", adv_active, act_exp);
        check("apply_pulse", {15'h0000, adv_apply}, 16'h0001);
        check("apply_cause", {13'h0000, apply_cause}, 16'h0001);
        host_u.rd(ADV_REG_IDX, d, v);
        check("stored_word", d, act_exp);
    endtask

    // Mid-run reset brings back the default word and clears the cause
    task automatic s_mid_reset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        act_exp = ADV_RESET_VAL;
        s_reset();
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        n_fail     = 0;
        n_compared = 0;
        act_exp    = ADV_RESET_VAL;
        rst_n      = 1'b0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        s_reset();
        s_write(ADV_REG_IDX, 16'hFFFF, 16'hBDFF);
        s_write(ADV_REG_IDX, 16'h0000, 16'h0000);
        s_write(5'h05, 16'h1234, 16'h0000);
        s_write(ADV_REG_IDX, 16'h4200, 16'h0000);
        s_apply(0, 16'h2C01);
        s_apply(1, 16'h11E1);
        s_apply(2, 16'h0A81);
        s_apply(3, 16'h3DE1);
        s_apply(1, 16'h3DE1);
        s_next_page(1'b1, 16'h81E1, 1'b1);
        s_next_page(1'b0, 16'h81E1, 1'b0);
        s_next_page(1'b1, 16'h01E1, 1'b0);
        s_write_apply(16'h7E1F);
        s_mid_reset();
        close_out();
    end
endmodule

`default_nettype wire
